// ==== two_wire_map.vh ====
/*
 * Register offsets, field positions, reset values and status codes of the
 * two-wire slave receiver.
 * Assumes it is included by bare name from the design file; it holds only
 * definitions.
 */
`ifndef TWO_WIRE_MAP_VH
`define TWO_WIRE_MAP_VH

// Byte offsets on the AHB-Lite register window.
`define OFS_OWN_ID      4'h0
`define OFS_CTRL        4'h4
`define OFS_BUS_STATE   4'h8
`define OFS_BYTE_BUF    4'hc

// Control register field positions.
`define CTRL_IRQ_FLAG   7
`define CTRL_ACK_EN     6
`define CTRL_BEGIN      5
`define CTRL_HALT       4
`define CTRL_WCOL       3
`define CTRL_IFACE_EN   2
`define CTRL_IRQ_EN     0

// Own-id register: bit 0 enables the broadcast call.
`define OWN_BCAST_BIT   0

// Reset values.
`define RST_OWN_ID      8'h00
`define RST_CTRL        8'h00
`define RST_PRESCALE    2'h0
`define RST_BYTE_BUF    8'hff

// Status codes, prescaler bits taken as zero.
`define ST_OWN_WR       8'h60
`define ST_ARB_OWN_WR   8'h68
`define ST_BCAST        8'h70
`define ST_ARB_BCAST    8'h78
`define ST_DATA_ACK     8'h80
`define ST_DATA_NACK    8'h88
`define ST_BC_DATA_ACK  8'h90
`define ST_BC_DATA_NACK 8'h98
`define ST_STOP_RESTART 8'ha0
`define ST_NO_INFO      8'hf8

// Bus address of the broadcast call.
`define BCAST_ADDR      7'h00

`endif

// ==== two_wire_slave_receiver.v ====
/*
 * Slave-receiver part of a byte-oriented two-wire serial interface with an
 * AHB-Lite register port.
 * Assumes: one clock hclk, SCL and SDA arrive asynchronously and are
 * open-drain (the pad drives low while the enable is high), master logic
 * of the same clock reports a lost arbitration, power logic reports sleep.
 */
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
// Operation
// - Match upper seven own-id bits against the received bus address.
// - Own-id bit zero one enables answering the broadcast call address.
// - Acknowledge own or broadcast address only while ack_enable is one.
// - Wait to be addressed; direction zero receives, one transmits; this receiver leaves direction one unacknowledged.
// - After own address plus write, set irq_flag and valid status.
// - Addressed after lost arbitration reports 0x68 or 0x78.
// - Clearing ack_enable mid-transfer makes the next data byte not-acked.
// - With ack_enable zero, ignore own address yet keep watching the bus.
// - In sleep with ack_enable set, still recognise and ack addresses.
// - Address match in sleep wakes the part; SCL held until flag clear.
// - After sleep wake-up the byte buffer need not hold the bus byte.
// - Own address with write received and acked reports 0x60.
// - Broadcast call received and acked reports 0x70.
// - Data byte acked reports 0x80, not acked reports 0x88.
// - Clearing the flag in 0x60-0x80 receives next byte, acks per enable.
// - After 0x88 and flag clear, drop to the not-addressed slave state.
// - Leaving addressed state with begin_request set starts when bus free.
// - Broadcast data byte reports 0x90 when acked, 0x98 when not.
// - STOP or repeated START while addressed reports 0xA0, then idle.
`include "two_wire_map.vh"

module two_wire_slave_receiver (
    input  wire        hclk,        // System clock, 25 MHz.
    input  wire        hresetn,     // Asynchronous reset, active low.
    input  wire        hsel,        // Slave select.
    input  wire [31:0] haddr,       // Byte address.
    input  wire [1:0]  htrans,      // Transfer type.
    input  wire        hwrite,      // Write when high.
    input  wire [2:0]  hsize,       // Transfer size.
    input  wire [31:0] hwdata,      // Write data.
    input  wire        hready,      // Bus ready in.
    output reg  [31:0] hrdata,      // Read data.
    output reg         hreadyout,   // Always ready.
    output reg         hresp,       // Always OKAY.
    input  wire        scl_i,       // Bus clock level.
    input  wire        sda_i,       // Bus data level.
    output reg         scl_o,       // Bus clock drive level, low.
    output reg         scl_oe,      // Pulls the bus clock low.
    output reg         sda_o,       // Bus data drive level, low.
    output reg         sda_oe,      // Pulls the bus data low.
    input  wire        arb_lost,    // Master lost arbitration, level.
    input  wire        sleep_req,   // Part is in a deep sleep mode.
    output reg         wake_req,    // Wake request to power logic.
    output reg         start_req    // One-cycle request to send a START.
);

    // Receive phases.
    localparam [2:0] PH_IDLE = 3'h0; // Not addressed, waiting for START.
    localparam [2:0] PH_ADDR = 3'h1; // Shifting the address byte.
    localparam [2:0] PH_AACK = 3'h2; // Address acknowledge slot.
    localparam [2:0] PH_DATA = 3'h3; // Shifting a data byte.
    localparam [2:0] PH_DACK = 3'h4; // Data acknowledge slot.
    localparam [2:0] PH_HOLD = 3'h5; // Flag set, SCL held low.

    // Register file.
    reg  [7:0] own_id_r;
    reg  [7:0] ctrl_r;
    reg  [1:0] prescale_r;
    reg  [7:0] byte_buffer_r;
    reg  [7:0] status_r;

    // Synchronisers and edge history.
    reg        scl_s1_r;
    reg        scl_s2_r;
    reg        scl_d_r;
    reg        sda_s1_r;
    reg        sda_s2_r;
    reg        sda_d_r;

    // Receive engine.
    reg  [2:0] phase_r;
    reg  [3:0] bitcnt_r;
    reg  [7:0] shift_r;
    reg        gc_r;          // Addressed by the broadcast call.
    reg        addressed_r;
    reg        acked_r;       // Current slot carries our acknowledge.
    reg        to_idle_r;     // Drop out of address after flag clear.
    reg        busy_r;        // Bus between START and STOP.
    reg        start_pend_r;

    // AHB-Lite data phase capture.
    reg        wr_pend_r;
    reg  [3:0] wr_ofs_r;

    wire       ack_enable = ctrl_r[`CTRL_ACK_EN];
    wire       iface_en   = ctrl_r[`CTRL_IFACE_EN];
    wire       irq_flag   = ctrl_r[`CTRL_IRQ_FLAG];

    // Bus conditions seen on the synchronised lines.
    wire       scl_rise   = scl_s2_r & ~scl_d_r;
    wire       scl_fall   = ~scl_s2_r & scl_d_r;
    wire       start_cond = scl_s2_r & scl_d_r & ~sda_s2_r & sda_d_r;
    wire       stop_cond  = scl_s2_r & scl_d_r & sda_s2_r & ~sda_d_r;

    // Address decision, made at the end of the eighth address bit.
    wire       own_hit = (shift_r[7:1] == own_id_r[7:1]);
    wire       gc_hit  = (shift_r[7:1] == `BCAST_ADDR) &
                         own_id_r[`OWN_BCAST_BIT];
    wire       wr_dir  = ~shift_r[0];
    wire       addr_ok = (own_hit | gc_hit) & wr_dir & ack_enable;

    // Software clear of the flag: write of one to its bit.
    wire       ctrl_wr   = wr_pend_r & (wr_ofs_r == `OFS_CTRL);
    wire       flag_clr  = ctrl_wr & hwdata[`CTRL_IRQ_FLAG];

    // Hardware events that raise the flag.
    reg        ev_set;
    reg  [7:0] ev_code;

    wire       ahb_go = hsel & hready & htrans[1];

    // Two-flip-flop synchronisers; the second stage and its delayed copy feed logic.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r  <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r  <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r  <= sda_s2_r;
        end
    end

    // Event decode: which status the next flag setting reports.
    always @* begin
        ev_set  = 1'b0;
        ev_code = `ST_NO_INFO;
        if (iface_en) begin
            if ((start_cond | stop_cond) && addressed_r &&
                phase_r != PH_HOLD) begin
                ev_set  = 1'b1;
                ev_code = `ST_STOP_RESTART;
            end else if (scl_fall && phase_r == PH_AACK) begin
                ev_set  = 1'b1;
                if (gc_r)
                    ev_code = arb_lost ? `ST_ARB_BCAST
                                       : `ST_BCAST;
                else
                    ev_code = arb_lost ? `ST_ARB_OWN_WR
                                       : `ST_OWN_WR;
            end else if (scl_fall && phase_r == PH_DACK) begin
                ev_set  = 1'b1;
                if (gc_r)
                    ev_code = acked_r ? `ST_BC_DATA_ACK
                                      : `ST_BC_DATA_NACK;
                else
                    ev_code = acked_r ? `ST_DATA_ACK
                                      : `ST_DATA_NACK;
            end
        end
    end

    // Receive engine: shifts bits, answers acknowledge slots and stretches.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r      <= PH_IDLE;
            bitcnt_r     <= 4'h0;
            shift_r      <= 8'h00;
            gc_r         <= 1'b0;
            addressed_r  <= 1'b0;
            acked_r      <= 1'b0;
            to_idle_r    <= 1'b0;
            busy_r       <= 1'b0;
            start_pend_r <= 1'b0;
            start_req    <= 1'b0;
            sda_oe       <= 1'b0;
            scl_oe       <= 1'b0;
            sda_o        <= 1'b0;
            scl_o        <= 1'b0;
            wake_req     <= 1'b0;
        end else begin
            start_req <= 1'b0;
            if (start_cond)
                busy_r <= 1'b1;
            else if (stop_cond)
                busy_r <= 1'b0;
            // A pending START goes out only once the bus is free.
            if (start_pend_r && !busy_r && !start_cond) begin
                start_req    <= 1'b1;
                start_pend_r <= 1'b0;
            end
            if (!iface_en) begin
                phase_r     <= PH_IDLE;
                addressed_r <= 1'b0;
                sda_oe      <= 1'b0;
                scl_oe      <= 1'b0;
                wake_req    <= 1'b0;
            end else if (phase_r == PH_HOLD) begin
                // Clock stays low until software clears the flag.
                if (flag_clr) begin
                    scl_oe   <= 1'b0;
                    wake_req <= 1'b0;
                    bitcnt_r <= 4'h0;
                    if (to_idle_r) begin
                        phase_r     <= PH_IDLE;
                        addressed_r <= 1'b0;
                        start_pend_r <= ctrl_r[`CTRL_BEGIN] |
                                        hwdata[`CTRL_BEGIN];
                    end else begin
                        phase_r <= PH_DATA;
                    end
                end
            end else if (start_cond) begin
                // Any START, repeated or not, restarts address shifting.
                phase_r     <= PH_ADDR;
                bitcnt_r    <= 4'h0;
                sda_oe      <= 1'b0;
                addressed_r <= 1'b0;
                if (addressed_r && ctrl_r[`CTRL_BEGIN])
                    start_pend_r <= 1'b1;
            end else if (stop_cond) begin
                phase_r     <= PH_IDLE;
                sda_oe      <= 1'b0;
                if (addressed_r && ctrl_r[`CTRL_BEGIN])
                    start_pend_r <= 1'b1;
                addressed_r <= 1'b0;
            end else begin
                case (phase_r)
                    PH_ADDR, PH_DATA: begin
                        if (scl_rise && bitcnt_r != 4'h8) begin
                            shift_r  <= {shift_r[6:0], sda_s2_r};
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end else if (scl_fall && bitcnt_r == 4'h8) begin
                            if (phase_r == PH_ADDR) begin
                                // Without ack_enable the address is let
                                // pass, but the bus is still watched.
                                if (addr_ok) begin
                                    phase_r  <= PH_AACK;
                                    sda_oe   <= 1'b1;
                                    gc_r     <= gc_hit & ~own_hit;
                                    wake_req <= sleep_req;
                                end else begin
                                    phase_r <= PH_IDLE;
                                end
                            end else begin
                                phase_r <= PH_DACK;
                                acked_r <= ack_enable;
                                sda_oe  <= ack_enable;
                            end
                        end
                    end
                    PH_AACK, PH_DACK: begin
                        if (scl_fall) begin
                            // Release data and hold the clock low.
                            sda_oe      <= 1'b0;
                            scl_oe      <= 1'b1;
                            addressed_r <= 1'b1;
                            phase_r     <= PH_HOLD;
                            to_idle_r   <= (phase_r == PH_DACK) &
                                           ~acked_r;
                        end
                    end
                    PH_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        phase_r <= PH_IDLE;
                    end
                endcase
            end
        end
    end

    // Control, status and byte buffer registers.
    // The flag set by hardware wins over a clear in the same cycle.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            own_id_r      <= `RST_OWN_ID;
            ctrl_r        <= `RST_CTRL;
            prescale_r    <= `RST_PRESCALE;
            byte_buffer_r <= `RST_BYTE_BUF;
            status_r      <= `ST_NO_INFO;
        end else begin
            if (wr_pend_r) begin
                case (wr_ofs_r)
                    `OFS_OWN_ID:    own_id_r   <= hwdata[7:0];
                    `OFS_BUS_STATE: prescale_r <= hwdata[1:0];
                    `OFS_BYTE_BUF: begin
                        if (irq_flag)
                            byte_buffer_r <= hwdata[7:0];
                        else
                            ctrl_r[`CTRL_WCOL] <= 1'b1;
                    end
                    `OFS_CTRL: begin
                        ctrl_r[`CTRL_ACK_EN]   <= hwdata[`CTRL_ACK_EN];
                        ctrl_r[`CTRL_BEGIN]    <= hwdata[`CTRL_BEGIN];
                        ctrl_r[`CTRL_HALT]     <= hwdata[`CTRL_HALT];
                        ctrl_r[`CTRL_IFACE_EN] <= hwdata[`CTRL_IFACE_EN];
                        ctrl_r[`CTRL_IRQ_EN]   <= hwdata[`CTRL_IRQ_EN];
                        if (hwdata[`CTRL_IRQ_FLAG]) begin
                            ctrl_r[`CTRL_IRQ_FLAG] <= 1'b0;
                            ctrl_r[`CTRL_WCOL]     <= 1'b0;
                            status_r               <= `ST_NO_INFO;
                        end
                    end
                    default: begin
                        status_r <= status_r;
                    end
                endcase
            end
            // Received data is latched at the acknowledge slot and kept
            // until the flag clears; sleep leaves it unspecified.
            if (iface_en && scl_fall && phase_r == PH_DATA &&
                bitcnt_r == 4'h8 && !sleep_req)
                byte_buffer_r <= shift_r;
            if (ev_set) begin
                ctrl_r[`CTRL_IRQ_FLAG] <= 1'b1;
                status_r               <= ev_code;
            end
        end
    end

    // AHB-Lite slave: zero wait states, reads answered from flops.
    // Only the low byte of each word is used; upper bits read as zero.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r  <= 4'h0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= ahb_go & hwrite & (haddr[31:4] == 28'h0000000);
            wr_ofs_r  <= haddr[3:0];
            if (ahb_go && !hwrite) begin
                case (haddr)
                    {28'h0000000, `OFS_OWN_ID}:
                        hrdata <= {24'h000000, own_id_r};
                    {28'h0000000, `OFS_CTRL}:
                        hrdata <= {24'h000000, ctrl_r};
                    {28'h0000000, `OFS_BUS_STATE}:
                        hrdata <= {24'h000000, status_r[7:3], 1'b0,
                                   prescale_r};
                    {28'h0000000, `OFS_BYTE_BUF}:
                        hrdata <= {24'h000000, byte_buffer_r};
                    default:
                        hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // two_wire_slave_receiver

// ==== two_wire_slave_receiver_asserts.sv ====
/* Concurrent checks on the ports of the two-wire slave receiver.
   Assumes the register map header and one clock domain on hclk. */
`include "two_wire_map.vh"

module two_wire_slave_receiver_asserts (
    input wire logic        hclk,      // System clock.
    input wire logic        hresetn,   // Reset, active low.
    input wire logic        hsel,      // Slave select.
    input wire logic [31:0] haddr,     // Byte address.
    input wire logic [1:0]  htrans,    // Transfer type.
    input wire logic        hwrite,    // Write when high.
    input wire logic [31:0] hwdata,    // Write data.
    input wire logic        hready,    // Bus ready in.
    input wire logic        hreadyout, // Ready out.
    input wire logic        hresp,     // Response.
    input wire logic        scl_oe,    // Clock pull-down.
    input wire logic        sda_oe,    // Data pull-down.
    input wire logic        sleep_req, // Deep sleep.
    input wire logic        wake_req,  // Wake request.
    input wire logic        start_req  // START request.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_q;
    logic ack_r;
    logic clr;

    // Shadow of ack_enable ANDed with the interface enable, updated as the design updates its copy.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q  <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite
                    && haddr[3:0] == `OFS_CTRL;
            if (wr_q) begin
                ack_r <= hwdata[`CTRL_ACK_EN] && hwdata[`CTRL_IFACE_EN];
            end
        end
    end

    // Data phase of a control write that clears the flag.
    assign clr = wr_q && hwdata[`CTRL_IRQ_FLAG];

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence clr_s;
        scl_oe && clr;
    endsequence
    sequence ack_end_s;
        $fell(sda_oe);
    endsequence

    stretch_hold_a: assert property (scl_oe && !clr |=> scl_oe)
        else $error("clock stretch dropped without a flag clear");
    stretch_release_a: assert property (clr_s |=> !scl_oe)
        else $error("clock stretch kept after a flag clear");
    ack_stretch_a: assert property (ack_end_s |-> scl_oe)
        else $error("ack slot ended without the flag stretch");
    ack_gate_a: assert property ($rose(sda_oe) |-> $past(ack_r))
        else $error("ack driven while ack_enable is zero");
    wake_sleep_a: assert property ($rose(wake_req) |-> $past(sleep_req))
        else $error("wake request outside sleep");
    wake_hold_a: assert property (wake_req && !clr |=> wake_req)
        else $error("wake request dropped before a flag clear");
    start_pulse_a: assert property (start_req |=> !start_req)
        else $error("start request longer than one cycle");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus response not ready and OKAY");
endmodule // two_wire_slave_receiver_asserts

bind two_wire_slave_receiver two_wire_slave_receiver_asserts
    two_wire_slave_receiver_asserts_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .sleep_req(sleep_req), .wake_req(wake_req), .start_req(start_req));

// ==== bus_master_model.sv ====
/* Behavioural two-wire bus master transmitter.
   Assumes open-drain lines whose pull-ups the bench resolves. */
module bus_master_model (
    input  wire logic scl_w,    // Resolved bus clock.
    input  wire logic sda_w,    // Resolved bus data.
    output logic      scl_pull, // Pulls the bus clock low.
    output logic      sda_pull  // Pulls the bus data low.
);
    timeunit 1ns;
    timeprecision 1ns;

    // Both lines idle high between frames; the clock stands still.
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // Releases the clock; a stretching slave makes this wait.
    task automatic clk_high();
        scl_pull = 1'b0;
        wait (scl_w === 1'b1);
        #83;
    endtask

    // Odd offsets keep the link edges away from the hclk edges.
    task automatic start_c();
        #7;
        sda_pull = 1'b1;
        #160;
        scl_pull = 1'b1;
        #80;
    endtask

    // Eight bits MSB first, then the ack slot; ack is 1 when pulled low.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull = ~b[i];
            #80;
            clk_high();
            #77;
            scl_pull = 1'b1;
            #80;
        end
        sda_pull = 1'b0;
        #80;
        clk_high();
        ack = ~sda_w;
        #77;
        scl_pull = 1'b1;
        #80;
    endtask

    task automatic stop_c();
        sda_pull = 1'b1;
        #80;
        clk_high();
        #80;
        sda_pull = 1'b0;
        #160;
    endtask
endmodule // bus_master_model

// ==== two_wire_slave_receiver_tb.sv ====
/* Self-checking bench: registers over AHB-Lite, frames from a master model.
   Assumes the map header, the master model and the checker come first. */
`include "two_wire_map.vh"

module two_wire_slave_receiver_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hsel, hwrite, arb_lost, sleep_req;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, scl_oe, sda_oe, wake_req, start_req;
    logic        m_scl, m_sda, scl_w, sda_w, start_seen, scl_o, sda_o;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cyc = 0;

    // Open-drain lines with pull-ups: low if either party pulls.
    assign scl_w = ~(scl_oe | m_scl);
    assign sda_w = ~(sda_oe | m_sda);

    two_wire_slave_receiver two_wire_slave_receiver_i (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .arb_lost(arb_lost),
        .sleep_req(sleep_req), .wake_req(wake_req), .start_req(start_req));
    bus_master_model bus_master_model_i (.scl_w(scl_w), .sda_w(sda_w),
        .scl_pull(m_scl), .sda_pull(m_sda));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // Catches the one-cycle START pulse; a hang ends the run.
    always @(posedge hclk) begin
        cyc++;
        if (start_req === 1'b1) start_seen <= 1'b1;
        if (cyc == 40000) begin
            n_fail++;
            results();
        end
    end

    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h got %h", nm, e, g);
        end
    endtask

    // One single transfer: address phase, then data phase.
    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] q;
        ahb(1'b1, a, {24'h0, d}, q);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        ahb(1'b0, a, 32'h0, q);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic [31:0] e [5] = '{32'h0, 32'h0, 32'hf8, 32'hff, 32'h0};
        for (int i = 0; i < 5; i++) begin
            rd(32'(i * 4), q);
            chk("reset value", e[i], q);
        end
        wr(`OFS_OWN_ID, 8'ha7);
        rd(`OFS_OWN_ID, q);
        chk("own_id rw", 32'ha7, q);
        $display("Test reset done");
    endtask

    // Addresses the device once; st of zero means it must stay silent.
    task automatic probe(input logic [7:0] own, ctl, adr, st);
        logic        ack;
        logic [31:0] q;
        wr(`OFS_OWN_ID, own);
        wr(`OFS_CTRL, ctl);
        bus_master_model_i.start_c();
        bus_master_model_i.send_byte(adr, ack);
        chk("addr ack", {31'h0, st != 8'h0}, {31'h0, ack});
        rd(`OFS_CTRL, q);
        chk("flag", {31'h0, st != 8'h0}, {31'h0, q[7]});
        rd(`OFS_BUS_STATE, q);
        chk("status", st != 8'h0 ? st : 8'hf8, q & 32'hf8);
        if (st != 8'h0) begin
            wr(`OFS_CTRL, ctl | 8'h80);
            bus_master_model_i.send_byte(8'ha5, ack);
            rd(`OFS_BYTE_BUF, q);
            chk("data", 32'ha5, q);
            rd(`OFS_BUS_STATE, q);
            chk("data status", st[4] ? 8'h90 : 8'h80, q);
            wr(`OFS_CTRL, ctl | 8'h80);
        end
        bus_master_model_i.stop_c();
        rd(`OFS_BUS_STATE, q);
        chk("stop status", st != 8'h0 ? 8'ha0 : 8'hf8, q);
        wr(`OFS_CTRL, ctl | 8'h80);
    endtask

    task automatic t_address();
        probe(8'h52, 8'h44, 8'h52, `ST_OWN_WR);
        probe(8'h52, 8'h04, 8'h52, 8'h00);
        probe(8'h52, 8'h44, 8'h53, 8'h00);
        probe(8'h52, 8'h44, 8'h54, 8'h00);
        probe(8'h52, 8'h44, 8'h00, 8'h00);
        probe(8'h53, 8'h44, 8'h00, `ST_BCAST);
        arb_lost <= 1'b1;
        probe(8'h52, 8'h44, 8'h52, `ST_ARB_OWN_WR);
        probe(8'h53, 8'h44, 8'h00, `ST_ARB_BCAST);
        arb_lost <= 1'b0;
        $display("Test address done");
    endtask

    task automatic t_nack();
        logic        ack;
        logic [31:0] q;
        wr(`OFS_OWN_ID, 8'h52);
        wr(`OFS_CTRL, 8'h44);
        bus_master_model_i.start_c();
        bus_master_model_i.send_byte(8'h52, ack);
        wr(`OFS_CTRL, 8'h84);
        bus_master_model_i.send_byte(8'h3c, ack);
        chk("nack", 32'h0, {31'h0, ack});
        rd(`OFS_BUS_STATE, q);
        chk("nack status", 32'h88, q);
        rd(`OFS_BYTE_BUF, q);
        chk("nack data", 32'h3c, q);
        start_seen = 1'b0;
        wr(`OFS_CTRL, 8'he4);
        bus_master_model_i.send_byte(8'h11, ack);
        chk("not addressed", 32'h0, {31'h0, ack});
        bus_master_model_i.stop_c();
        rd(`OFS_BUS_STATE, q);
        chk("idle status", 32'hf8, q);
        chk("start pulse", 32'h1, {31'h0, start_seen});
        wr(`OFS_CTRL, 8'h44);
        $display("Test nack done");
    endtask

    task automatic t_sleep();
        logic        ack;
        logic [31:0] q;
        sleep_req <= 1'b1;
        bus_master_model_i.start_c();
        bus_master_model_i.send_byte(8'h52, ack);
        chk("sleep ack", 32'h1, {31'h0, ack});
        repeat (20) @(posedge hclk);
        chk("wake", 32'h1, {31'h0, wake_req});
        chk("held", 32'h1, {31'h0, scl_oe});
        sleep_req <= 1'b0;
        wr(`OFS_CTRL, 8'hc4);
        repeat (2) @(posedge hclk);
        chk("woken", 32'h0, {28'h0, scl_o, sda_o, wake_req, scl_oe});
        bus_master_model_i.send_byte(8'h77, ack);
        rd(`OFS_BYTE_BUF, q);
        chk("wake data", 32'h77, q);
        wr(`OFS_CTRL, 8'hc4);
        bus_master_model_i.stop_c();
        wr(`OFS_CTRL, 8'hc4);
        $display("Test sleep done");
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        arb_lost = 1'b0;
        sleep_req = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        start_seen = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_address();
        t_nack();
        t_sleep();
        results();
    end
endmodule // two_wire_slave_receiver_tb
